// ===== hw/urb_defs.svh
`ifndef URB_DEFS_SVH
`define URB_DEFS_SVH

// register byte offsets
`define URB_OFS_MODE 8'h00
`define URB_OFS_ERR 8'h04
`define URB_OFS_BRG 8'h08
`define URB_OFS_RXB 8'h0C
`define URB_OFS_TXS 8'h10
`define URB_OFS_STAT 8'h14

// decoded register indices, none marks an unmapped address
`define URB_IDX_MODE 3'h0
`define URB_IDX_ERR 3'h1
`define URB_IDX_BRG 3'h2
`define URB_IDX_RXB 3'h3
`define URB_IDX_TXS 3'h4
`define URB_IDX_STAT 3'h5
`define URB_IDX_NONE 3'h7

// serial_mode_control fields
`define URB_MODE_PWR 7
`define URB_MODE_TXE 6
`define URB_MODE_RXE 5
`define URB_MODE_PAR_HI 4
`define URB_MODE_PAR_LO 3
`define URB_MODE_CL8 2
`define URB_MODE_MASK 8'hFE
`define URB_MODE_RST 8'h00

// baud_divider_control fields
`define URB_BRG_SRC_HI 7
`define URB_BRG_SRC_LO 6
`define URB_BRG_DIV_HI 4
`define URB_BRG_DIV_LO 0
`define URB_BRG_MASK 8'hDF
`define URB_BRG_RST 8'h1F

// parity modes and base clock sources
`define URB_PAR_NONE 2'h0
`define URB_PAR_ZERO 2'h1
`define URB_PAR_ODD 2'h2
`define URB_PAR_EVEN 2'h3
`define URB_SRC_TMR 2'h0
`define URB_SRC_DIV2 2'h1
`define URB_SRC_DIV8 2'h2
`define URB_SRC_DIV32 2'h3

// divider floor and last data bit index per length
`define URB_DIV_MIN 5'h08
`define URB_LAST_BIT8 3'h7
`define URB_LAST_BIT7 3'h6

`endif

// ===== hw/urb_pkg.sv
package urb_pkg;
   localparam int DIV_W = 5;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} urb_rx_state_t;

   typedef struct packed {
      logic pe;
      logic fe;
      logic ove;
   } urb_err_t;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
   } urb_cnt_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] brg;
      logic [7:0] txs;
      logic [7:0] rxbuf;
      urb_err_t err;
      logic full;
      logic [2:0] pin_s;
      logic pin_lvl;
      logic [2:0] tmr_s;
      logic tmr_lvl;
      logic [4:0] prs;
      urb_rx_state_t fsm;
      logic [7:0] sh;
      logic [2:0] bitn;
      logic par_acc;
      logic pend_pe;
      logic half;
      logic irq;
      logic dp_wr;
      logic dp_rd;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
   } urb_state_t;
endpackage : urb_pkg

// ===== hw/urb_brg_cnt.sv
`timescale 1ns/10ps
module urb_brg_cnt (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic run,
   input wire logic clr,
   input wire logic tick,
   input wire logic [urb_pkg::DIV_W-1:0] k,
   output logic [urb_pkg::DIV_W-1:0] count,
   output logic match
);
   import urb_pkg::*;

   urb_cnt_t state_reg;
   urb_cnt_t state_next;

   // count base ticks modulo k, held at zero while stopped
   always_comb begin
      state_next = state_reg;
      if (!run || clr) begin
         state_next.cnt = '0;
      end else if (tick) begin
         state_next.cnt = (state_reg.cnt == k - 1'b1) ? '0 : state_reg.cnt + 1'b1;
      end
   end

   // match marks k base ticks since the last wrap
   assign match = run && !clr && tick && (state_reg.cnt == k - 1'b1);
   assign count = state_reg.cnt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_cnt_held_zero: assert property (clk_en && !run |=> count == '0)
      else $error("stopped counter not at zero");

   chk_cnt_wraps_k: assert property (clk_en && match |=> count == '0)
      else $error("counter did not wrap after k ticks");
endmodule : urb_brg_cnt

// ===== hw/urb_rx_top.sv
`timescale 1ns/10ps
`include "urb_defs.svh"
module urb_rx_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic serial_in_pin,
   input wire logic aux_timer_output,
   output logic rx_done_irq,
   output urb_pkg::urb_err_t rx_error_status
);
   import urb_pkg::*;

   urb_state_t state_reg;
   urb_state_t state_next;

   logic unit_power_on;
   logic transmit_enable_bit;
   logic receive_enable_bit;
   logic rx_on;
   logic cl8;
   logic [1:0] par_mode;
   logic [1:0] src_sel;
   logic [DIV_W-1:0] k_div;
   logic base_tick;
   logic tmr_rise;
   logic pin_stable;
   logic pin_fall;
   logic take;
   logic tx_wr;
   logic rd_err;
   logic rd_buf;
   logic rx_match;
   logic samp;
   logic frame_done;
   logic [DIV_W-1:0] rx_cnt;
   logic [DIV_W-1:0] tx_cnt;
   urb_err_t new_err;

   // address decode shared by the write and read paths
   function automatic logic [2:0] urb_dec(input logic [7:0] a);
      case (a)
         `URB_OFS_MODE: urb_dec = `URB_IDX_MODE;
         `URB_OFS_ERR: urb_dec = `URB_IDX_ERR;
         `URB_OFS_BRG: urb_dec = `URB_IDX_BRG;
         `URB_OFS_RXB: urb_dec = `URB_IDX_RXB;
         `URB_OFS_TXS: urb_dec = `URB_IDX_TXS;
         `URB_OFS_STAT: urb_dec = `URB_IDX_STAT;
         default: urb_dec = `URB_IDX_NONE;
      endcase
   endfunction : urb_dec

   // configuration fields
   assign unit_power_on = state_reg.mode[`URB_MODE_PWR];
   assign transmit_enable_bit = state_reg.mode[`URB_MODE_TXE];
   assign receive_enable_bit = state_reg.mode[`URB_MODE_RXE];
   assign rx_on = unit_power_on && receive_enable_bit;
   assign cl8 = state_reg.mode[`URB_MODE_CL8];
   assign par_mode = state_reg.mode[`URB_MODE_PAR_HI:`URB_MODE_PAR_LO];
   assign src_sel = state_reg.brg[`URB_BRG_SRC_HI:`URB_BRG_SRC_LO];
   // divider floor; values under the legal range act as the minimum
   assign k_div = (state_reg.brg[`URB_BRG_DIV_HI:`URB_BRG_DIV_LO] < `URB_DIV_MIN) ?
      `URB_DIV_MIN : state_reg.brg[`URB_BRG_DIV_HI:`URB_BRG_DIV_LO];

   // filtered edges: second and third synchroniser stages must agree
   assign tmr_rise = (state_reg.tmr_s[1] == state_reg.tmr_s[2]) && state_reg.tmr_s[1] &&
      !state_reg.tmr_lvl;
   assign pin_stable = state_reg.pin_s[1] == state_reg.pin_s[2];
   // falling edge seen on the filtered level
   assign pin_fall = rx_on && pin_stable && !state_reg.pin_s[1] && state_reg.pin_lvl;

   // base clock select, one tick per base clock period
   always_comb begin
      case (src_sel)
         `URB_SRC_TMR: base_tick = tmr_rise;
         `URB_SRC_DIV2: base_tick = state_reg.prs[0];
         `URB_SRC_DIV8: base_tick = &state_reg.prs[2:0];
         default: base_tick = &state_reg.prs[4:0];
      endcase
      if (!unit_power_on) begin
         base_tick = 1'b0;
      end
   end

   urb_brg_cnt u_tx_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .run(unit_power_on && transmit_enable_bit),
      .clr(tx_wr),
      .tick(base_tick),
      .k(k_div),
      .count(tx_cnt),
      .match()
   );

   urb_brg_cnt u_rx_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .run(rx_on && (state_reg.fsm != RX_IDLE)),
      .clr(1'b0),
      .tick(base_tick),
      .k(k_div),
      .count(rx_cnt),
      .match(rx_match)
   );

   // every second match is a bit centre
   assign samp = rx_match && state_reg.half;

   // bus handshake; reads take one wait state so the data is registered
   assign take = hsel && hready && htrans[1];
   assign hreadyout = !state_reg.dp_rd;
   assign hresp = 1'b0;
   assign hrdata = state_reg.rdata;
   assign rx_done_irq = state_reg.irq;
   assign rx_error_status = state_reg.err;

   // next state: bus, synchronisers, receiver
   always_comb begin
      state_next = state_reg;
      tx_wr = 1'b0;
      rd_err = 1'b0;
      rd_buf = 1'b0;
      frame_done = 1'b0;
      new_err = '0;

      // address phase capture
      state_next.dp_wr = take && hwrite;
      state_next.dp_rd = take && !hwrite;
      if (take) begin
         state_next.dp_addr = haddr[7:0];
      end

      // write data phase, zero wait
      if (state_reg.dp_wr) begin
         case (urb_dec(state_reg.dp_addr))
            `URB_IDX_MODE: state_next.mode = hwdata[7:0] & `URB_MODE_MASK;
            `URB_IDX_BRG: state_next.brg = hwdata[7:0] & `URB_BRG_MASK;
            `URB_IDX_TXS: begin
               state_next.txs = hwdata[7:0];
               tx_wr = 1'b1;
            end
            default: ;
         endcase
      end

      // read data phase, data loaded in the wait cycle
      if (state_reg.dp_rd) begin
         case (urb_dec(state_reg.dp_addr))
            `URB_IDX_MODE: state_next.rdata = {24'h00_0000, state_reg.mode};
            `URB_IDX_ERR: begin
               state_next.rdata = {29'h0000_0000, state_reg.err};
               rd_err = 1'b1;
            end
            `URB_IDX_BRG: state_next.rdata = {24'h00_0000, state_reg.brg};
            `URB_IDX_RXB: begin
               state_next.rdata = {24'h00_0000, state_reg.rxbuf};
               rd_buf = 1'b1;
            end
            `URB_IDX_TXS: state_next.rdata = {24'h00_0000, state_reg.txs};
            `URB_IDX_STAT: state_next.rdata = {14'h0000, state_reg.fsm != RX_IDLE,
               state_reg.full, 3'h0, tx_cnt, 3'h0, rx_cnt};
            default: state_next.rdata = 32'h0000_0000;
         endcase
      end

      // synchronisers, the first stage feeds only the second
      state_next.pin_s = {state_reg.pin_s[1:0], serial_in_pin};
      state_next.tmr_s = {state_reg.tmr_s[1:0], aux_timer_output};
      if (state_reg.tmr_s[1] == state_reg.tmr_s[2]) begin
         state_next.tmr_lvl = state_reg.tmr_s[1];
      end
      if (!unit_power_on) begin
         state_next.pin_lvl = 1'b1;
      end else if (pin_stable) begin
         state_next.pin_lvl = state_reg.pin_s[1];
      end

      // peripheral clock prescaler
      state_next.prs = state_reg.prs + 1'b1;

      // half-bit phase toggles on each match once inside the frame
      if (rx_match && (state_reg.fsm != RX_START)) begin
         state_next.half = !state_reg.half;
      end

      case (state_reg.fsm)
         RX_IDLE: begin
            if (pin_fall) begin
               state_next.fsm = RX_START;
            end
         end
         RX_START: begin
            if (rx_match) begin
               state_next.fsm = state_reg.pin_lvl ? RX_IDLE : RX_DATA;
               state_next.half = 1'b0;
               state_next.bitn = 3'h0;
               state_next.par_acc = 1'b0;
               state_next.pend_pe = 1'b0;
            end
         end
         RX_DATA: begin
            if (samp) begin
               state_next.sh = {state_reg.pin_lvl, state_reg.sh[7:1]};
               state_next.par_acc = state_reg.par_acc ^ state_reg.pin_lvl;
               state_next.bitn = state_reg.bitn + 1'b1;
               if (state_reg.bitn == (cl8 ? `URB_LAST_BIT8 : `URB_LAST_BIT7)) begin
                  state_next.fsm = (par_mode == `URB_PAR_NONE) ? RX_STOP : RX_PARITY;
               end
            end
         end
         RX_PARITY: begin
            if (samp) begin
               case (par_mode)
                  `URB_PAR_EVEN: state_next.pend_pe = state_reg.par_acc ^ state_reg.pin_lvl;
                  `URB_PAR_ODD: state_next.pend_pe = !(state_reg.par_acc ^ state_reg.pin_lvl);
                  default: state_next.pend_pe = 1'b0;
               endcase
               state_next.fsm = RX_STOP;
            end
         end
         RX_STOP: begin
            if (samp) begin
               frame_done = 1'b1;
               state_next.fsm = RX_IDLE;
            end
         end
         default: state_next.fsm = RX_IDLE;
      endcase

      if (frame_done) begin
         new_err.pe = state_reg.pend_pe;
         new_err.fe = !state_reg.pin_lvl;
         new_err.ove = state_reg.full;
      end

      // read clears, a new flag wins
      state_next.err = (rd_err ? urb_err_t'(3'h0) : state_reg.err) | new_err;
      state_next.full = frame_done || (state_reg.full && !rd_buf);

      if (frame_done && !state_reg.full) begin
         state_next.rxbuf = cl8 ? state_reg.sh : {1'b0, state_reg.sh[7:1]};
      end

      // one line for done and error
      state_next.irq = frame_done;

      // receive disabled abandons the frame
      if (!rx_on) begin
         state_next.fsm = RX_IDLE;
      end

      if (!unit_power_on) begin
         state_next.err = '0;
         state_next.txs = 8'h00;
         state_next.rxbuf = 8'h00;
         state_next.full = 1'b0;
         state_next.prs = 5'h00;
         state_next.irq = 1'b0;
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= '0;
         state_reg.mode <= `URB_MODE_RST;
         state_reg.brg <= `URB_BRG_RST;
         state_reg.pin_s <= 3'h7;
         state_reg.pin_lvl <= 1'b1;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_stop_sample;
      clk_en && state_reg.fsm == RX_STOP && samp && rx_on;
   endsequence

   chk_done_irq_pulse: assert property (s_stop_sample |=> rx_done_irq ##1 !rx_done_irq)
      else $error("frame end did not give one irq pulse");

   chk_overrun_keeps_buf: assert property (s_stop_sample and state_reg.full && !rd_buf
      |=> $stable(state_reg.rxbuf) && rx_error_status.ove)
      else $error("overrun changed buffer or missed flag");

   chk_start_reject: assert property (clk_en && rx_on && state_reg.fsm == RX_START && rx_match
      && state_reg.pin_lvl |=> state_reg.fsm == RX_IDLE)
      else $error("high level accepted as start bit");

   chk_err_read_clear: assert property (clk_en && rd_err && !frame_done && unit_power_on
      |=> rx_error_status == '0)
      else $error("status read did not clear flags");

   chk_power_off_reset: assert property (clk_en && !unit_power_on
      |=> rx_error_status == '0 && state_reg.rxbuf == 8'h00 && state_reg.fsm == RX_IDLE)
      else $error("power off did not reset receiver");

   chk_pin_forced_high: assert property (clk_en && !unit_power_on |=> state_reg.pin_lvl)
      else $error("receive input not forced high");

   chk_idle_cnt_zero: assert property (clk_en && state_reg.fsm == RX_IDLE
      ##1 clk_en && state_reg.fsm == RX_IDLE |-> rx_cnt == '0)
      else $error("receive counter runs outside a frame");

   chk_base_low: assert property (!unit_power_on |-> !base_tick)
      else $error("base clock active with power off");
endmodule : urb_rx_top

// ===== bench/urb_tx_model.sv
`timescale 1ns/10ps
module urb_tx_model (
   output logic line
);
   // line idles high between frames, as an unloaded serial line does
   initial line = 1'b1;

   task send(input logic [7:0] d, input int nb, input int pm, input logic pf,
      input logic st, input time bt);
      logic par;
      par = ^(d & ((nb == 7) ? 8'h7F : 8'hFF));
      // small offset keeps edges away from the clock edge
      #7 line = 1'b0;
      #bt;
      for (int i = 0; i < nb; i++) begin
         line = d[i];
         #bt;
      end
      // parity bit, flipped on request to provoke an error
      if (pm != 0) begin
         line = ((pm == 3) ? par : (pm == 2) ? ~par : 1'b0) ^ pf;
         #bt;
      end
      // two stop bits sent, only the first may matter
      line = st;
      #bt;
      line = 1'b1;
      #bt;
   endtask : send

   // low pulse far shorter than the start check
   task glitch(input time w);
      line = 1'b0;
      #w line = 1'b1;
   endtask : glitch
endmodule : urb_tx_model

// ===== bench/tb_top.sv
`timescale 1ns/10ps
`include "urb_defs.svh"
module tb_top;
   import urb_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_line, tmr_out, rx_done_irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, tc;
   logic [7:0] kk;
   urb_err_t err_o;
   int fail_count, samples_checked, cyc;
   logic [1:0] src [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
   int dv [4] = '{2, 8, 4, 2};

   urb_rx_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_in_pin(rx_line),
      .aux_timer_output(tmr_out), .rx_done_irq(rx_done_irq), .rx_error_status(err_o));
   urb_tx_model far (.line(rx_line));

   // 40 MHz bus clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // timer runs from time zero, so it is going before its output is chosen
   // external timer output: one rising edge every 4 cycles
   always @(posedge hclk) tc <= tc + 2'h1;
   assign tmr_out = tc[1];

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // single word transfer; ready is looked at on the falling edge before the sampling edge
   task bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(negedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      @(posedge hclk);
   endtask : bus

   task wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask : rdc

   // cycles until the one-cycle pulse, -1 when it never shows
   task wait_irq(input int lim, output int c);
      c = -1;
      for (int i = 0; i < lim && c < 0; i++) begin
         @(negedge hclk);
         if (rx_done_irq === 1'b1) c = i;
      end
   endtask : wait_irq

   task rx(input logic [7:0] d, input int nb, pm, input logic pf, st, input int dvv);
      fork
         far.send(d, nb, pm, pf, st, 50 * kk * dvv);
         wait_irq(24 * kk * dvv + 60, cyc);
      join
   endtask : rx

   // frame, then flags on the pins and status, then buffer read as software should
   task frm(input logic [7:0] d, input int nb, pm, input logic pf, st, input logic [2:0] e,
      input logic [7:0] x);
      rx(d, nb, pm, pf, st, 2);
      chk(cyc >= 0, 1'b1);
      chk(err_o, e);
      rdc(`URB_OFS_ERR, {29'h0, e});
      rdc(`URB_OFS_RXB, {24'h0, x});
   endtask : frm

   task tend(input string s);
      $display("test %s finished", s);
   endtask : tend

   task test_done;
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // watchdog well beyond the expected run of about 9000 cycles
   initial begin
      #1000000;
      fail_count++;
      test_done;
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      tc = 2'h0;
      kk = 8'h08;
      fail_count = 0;
      samples_checked = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(`URB_OFS_MODE, 32'h0); // mode after reset
      rdc(`URB_OFS_BRG, 32'h1F); // divider after reset
      rdc(`URB_OFS_RXB, 32'h0); // buffer after reset
      rdc(8'h18, 32'h0); // unmapped reads zero
      wr(`URB_OFS_BRG, 8'h48);
      rx(8'h55, 8, 3, 1'b0, 1'b1, 2);
      chk(cyc, -1); // powered down ignores
      wr(`URB_OFS_MODE, 8'h9C);
      rx(8'h55, 8, 3, 1'b0, 1'b1, 2);
      chk(cyc, -1); // enable still off
      wr(`URB_OFS_MODE, 8'hBC);
      tend("enable");
      // timer, divide-by-2 and divide-by-8 sources, smallest and largest divider; stop sample sits 21k ticks in
      for (int i = 0; i < 4; i++) begin
         kk = (i == 3) ? 8'h1F : 8'h08;
         wr(`URB_OFS_BRG, {src[i], 1'b0, kk[4:0]});
         rx(8'h55 + 8'(i), 8, 3, 1'b0, 1'b1, dv[i]);
         chk(cyc >= 21 * kk * dv[i] && cyc <= 21 * kk * dv[i] + dv[i] + 10, 1'b1); // rate
         rdc(`URB_OFS_ERR, 32'h0); // clean frame
         rdc(`URB_OFS_RXB, 32'h55 + i); // source select
      end
      kk = 8'h08;
      wr(`URB_OFS_BRG, 8'h48);
      tend("baud");
      far.glitch(250);
      wait_irq(300, cyc);
      chk(cyc, -1); // start rejected
      frm(8'hA3, 8, 3, 1'b1, 1'b1, 3'h4, 8'hA3); // parity at end
      rdc(`URB_OFS_ERR, 32'h0); // read clears
      frm(8'h3C, 8, 3, 1'b0, 1'b0, 3'h2, 8'h3C); // framing error
      // buffer left unread, so the next frame must overrun
      rx(8'h11, 8, 3, 1'b0, 1'b1, 2);
      frm(8'h22, 8, 3, 1'b0, 1'b1, 3'h1, 8'h11); // overrun keeps old
      wr(`URB_OFS_MODE, 8'hB0);
      frm(8'h36, 7, 2, 1'b0, 1'b1, 3'h0, 8'h36); // seven bit odd
      frm(8'h36, 7, 2, 1'b1, 1'b1, 3'h4, 8'h36); // odd mismatch
      wr(`URB_OFS_MODE, 8'hAC);
      frm(8'hF0, 8, 1, 1'b1, 1'b1, 3'h0, 8'hF0); // zero parity
      wr(`URB_OFS_MODE, 8'hA4);
      frm(8'h0F, 8, 0, 1'b0, 1'b1, 3'h0, 8'h0F); // no parity
      tend("frames");
      wr(`URB_OFS_MODE, 8'hE4);
      wr(`URB_OFS_BRG, 8'hDF);
      wr(`URB_OFS_TXS, 8'h5A);
      bus(1'b0, `URB_OFS_STAT, 8'h00);
      chk(rd[12:8] < 5'h02, 1'b1); // write clears
      rdc(`URB_OFS_TXS, 32'h5A); // data kept
      wr(`URB_OFS_MODE, 8'hA4);
      bus(1'b0, `URB_OFS_STAT, 8'h00);
      chk(rd[12:8], 5'h00); // held at zero
      wr(`URB_OFS_MODE, 8'h84);
      bus(1'b0, `URB_OFS_STAT, 8'h00);
      chk(rd[4:0], 5'h00); // cleared when off
      tend("counters");
      wr(`URB_OFS_MODE, 8'hBC);
      wr(`URB_OFS_BRG, 8'h48);
      rx(8'h77, 8, 3, 1'b1, 1'b1, 2);
      chk(err_o, 3'h4); // flag on pins
      wr(`URB_OFS_MODE, 8'h3C);
      // mode lands at the last edge of the write, the wipe one edge later
      repeat (2) @(negedge hclk);
      chk(err_o, 3'h0); // power off wipes
      rdc(`URB_OFS_ERR, 32'h0); // status wiped
      rdc(`URB_OFS_RXB, 32'h0); // buffer wiped
      tend("power down");
      test_done;
   end
endmodule : tb_top
